// file: rtl/fdp_defs.svh
// Offsets, field positions, reset values and timing of the floppy data path
`ifndef FDP_DEFS_SVH
`define FDP_DEFS_SVH
// Register offsets on A2-0 and base on A9-3
`define FDP_BASE 7'h7e
`define FDP_OFS_STA 3'h0
`define FDP_OFS_MDR 3'h1
`define FDP_OFS_DOR 3'h2
`define FDP_OFS_CFG 3'h3
`define FDP_OFS_DSR 3'h4
`define FDP_OFS_DAT 3'h5
`define FDP_OFS_OPR 3'h6
`define FDP_OFS_CCR 3'h7
// Field positions
`define FDP_CFG_EN 3
`define FDP_CFG_ALT 2
`define FDP_DOR_RSTN 2
`define FDP_DOR_DMAEN 3
`define FDP_DSR_SWRST 7
`define FDP_OPR_RD 0
`define FDP_OPR_WR 1
`define FDP_OPR_FMT 2
`define FDP_CONF_EFIFO_N 5
`define FDP_MODE_FRD 0
`define FDP_MODE_FWR 1
`define FDP_MODE_BSTDIS 2
`define FDP_MODE_OD 3
`define FDP_MODE_DENS 4
`define FDP_PERP_ON 0
// Reset values
`define FDP_DOR_RST 8'h00
`define FDP_CFG_RST 8'h00
`define FDP_RATE_RST 2'h2
`define FDP_PCSEL_RST 3'h0
// Commands and fill bytes
`define FDP_CMD_MODE 8'h01
`define FDP_CMD_PERP 8'h12
`define FDP_CMD_CONFIGURE 8'h13
`define FDP_GAP_BYTE 8'h4e
`define FDP_PRE_BYTE 8'h00
// Timing
`define FDP_CLK_PS 50000
`define FDP_BIT_1M_NS 1000
`define FDP_BIT_500K_NS 2000
`define FDP_BIT_300K_NS 3333
`define FDP_BIT_250K_NS 4000
`define FDP_PC_STEP_PS 41667
`define FDP_PC_MAX_PS 250000
`define FDP_GAP2_STD 22
`define FDP_GAP2_PERP 41
`define FDP_LEAD_1M 38
`define FDP_LEAD_500K 19
`define FDP_PRE_LEN 12
`define FDP_LOCK_CNT 16
`define FDP_FIFO_DEPTH 16
`endif

// file: rtl/fdp_pkg.sv
// Types shared by the floppy data path modules
package fdp_pkg;
  typedef logic [1:0] fdp_rate_t;
  typedef logic [7:0] fdp_byte_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_GAP = 5'b00010,
    ST_PRE = 5'b00100,
    ST_WDAT = 5'b01000,
    ST_RDAT = 5'b10000
  } fdp_st_e;
endpackage

// file: rtl/fdp_dds.sv
// Digital data separator: phase tracking, preamble lock, bit recovery
`include "fdp_defs.svh"
module fdp_dds import fdp_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic i_pulse,
  input wire logic [5:0] i_half,
  output logic o_bit_vld,
  output logic o_bit,
  output logic o_locked
);
  logic [5:0] ph_ff;
  logic win_ff;
  logic seen_ff;
  logic [4:0] lock_cnt_ff;
  logic wrap;
  logic [5:0] mid;

  assign wrap = (ph_ff == i_half - 6'h01);
  assign mid = i_half >> 1;

  // Phase snaps to each pulse; simple but keeps jitter margin centred
  always_ff @(posedge i_mclk) begin
    if (i_rst || !i_run) begin
      ph_ff <= 6'h00;
      win_ff <= 1'b0;
      seen_ff <= 1'b0;
      lock_cnt_ff <= 5'h00;
      o_locked <= 1'b0;
      o_bit_vld <= 1'b0;
      o_bit <= 1'b0;
    end else begin
      o_bit_vld <= 1'b0;
      ph_ff <= i_pulse ? mid + 6'h01 : (wrap ? 6'h00 : ph_ff + 6'h01);
      if (wrap && !i_pulse) begin
        win_ff <= ~win_ff;
      end
      if (i_pulse && !o_locked) begin
        if (win_ff) begin
          lock_cnt_ff <= 5'h00;
          win_ff <= 1'b0;
        end else if (lock_cnt_ff == 5'(`FDP_LOCK_CNT - 1)) begin
          o_locked <= 1'b1;
        end else begin
          lock_cnt_ff <= lock_cnt_ff + 5'h01;
        end
      end
      if (i_pulse && win_ff && o_locked) begin
        seen_ff <= 1'b1;
      end
      if (wrap && win_ff && !i_pulse) begin
        o_bit_vld <= o_locked;
        o_bit <= seen_ff;
        seen_ff <= 1'b0;
      end
    end
  end
endmodule

// file: rtl/fdp_mfm.sv
// MFM serialiser with pattern-based write precompensation
`include "fdp_defs.svh"
module fdp_mfm import fdp_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic [5:0] i_half,
  input wire logic [2:0] i_pc,
  input wire fdp_byte_t i_byte,
  output logic o_byte_rdy,
  output logic o_pulse
);
  logic [7:0] sh_ff;
  logic [2:0] idx_ff;
  logic prev_ff;
  logic [5:0] ph_ff;
  logic win_ff;
  logic want_ff;
  logic [5:0] pos_ff;
  logic wrap;
  logic cur;
  logic nxt;
  logic [5:0] mid;

  assign wrap = (ph_ff == i_half - 6'h01);
  assign mid = i_half >> 1;
  assign cur = sh_ff[7];
  assign nxt = (idx_ff == 3'h7) ? 1'b0 : sh_ff[6];
  assign o_byte_rdy = i_run && wrap && win_ff && (idx_ff == 3'h7);

  // Cell timing follows the selected rate through i_half
  always_ff @(posedge i_mclk) begin
    if (i_rst || !i_run) begin
      sh_ff <= 8'h00;
      idx_ff <= 3'h7;
      prev_ff <= 1'b0;
      ph_ff <= 6'h00;
      win_ff <= 1'b1;
      want_ff <= 1'b0;
      pos_ff <= 6'h00;
      o_pulse <= 1'b0;
    end else begin
      o_pulse <= want_ff && (ph_ff == pos_ff);
      ph_ff <= wrap ? 6'h00 : ph_ff + 6'h01;
      if (wrap) begin
        win_ff <= ~win_ff;
        if (win_ff) begin
          // Data cell ends: next clock cell
          // clock only between zeros
          prev_ff <= (idx_ff == 3'h7) ? cur : prev_ff;
          want_ff <= !cur && !((idx_ff == 3'h7) ? i_byte[7] : sh_ff[6]);
          pos_ff <= mid;
          if (idx_ff == 3'h7) begin
            sh_ff <= i_byte;
            idx_ff <= 3'h0;
          end else begin
            sh_ff <= {sh_ff[6:0], 1'b0};
            idx_ff <= idx_ff + 3'h1;
          end
        end else begin
          want_ff <= cur;
          if (prev_ff && !nxt) begin
            pos_ff <= mid + 6'(i_pc);
          end else if (!prev_ff && nxt) begin
            pos_ff <= mid - 6'(i_pc);
          end else begin
            pos_ff <= mid;
          end
          prev_ff <= cur;
        end
      end
    end
  end
endmodule

// file: rtl/fdp_top.sv
// Floppy controller data path: host port, DMA, FIFO, separator, writer
// Overview of operation
// - controller runs only when enable bit set
// - reset: FIFO off, outputs push-pull
// - configure command puts FIFO in path
// - mode: FIFO enables, burst, open-drain, density
// - A9-3 with AEN decode, A2-0 select
// - interrupt and DRQ/DACK/TC handshake
// - config bit 2 picks drive mode
// - AT mode: DMA bit gates IRQ/DRQ
// - alternate mode: always driven, low polarity
// - four software-selected MFM data rates
// - default precompensation by data rate
// - software precompensation override up to 250ns
// - digital PLL separates bits into bytes
// - non-preamble lock forces reference re-lock
// - undecodable shifted bit gives CRC error
// - perpendicular mode at 500 Kbps and 1 Mbps
// - pre-erase lead 38 or 19 bytes
// - last written rate register wins
// - perpendicular 1 Mbps gap 2 is 41
// - write gate at pre-erase head position
`include "fdp_defs.svh"
module fdp_top import fdp_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [9:0] i_addr,
  input wire logic i_aen,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_dack_n,
  input wire logic i_tc,
  output logic o_irq,
  output logic o_irq_oe,
  output logic o_drq,
  output logic o_drq_oe,
  input wire logic i_read_data_n,
  output logic o_write_data_n,
  output logic o_write_data_oe,
  output logic o_write_gate_n,
  output logic o_write_gate_oe,
  output logic o_density_select,
  output logic o_density_oe
);
  localparam logic [5:0] HALF_1M = 6'(`FDP_BIT_1M_NS * 1000 / 2 / `FDP_CLK_PS);
  localparam logic [5:0] HALF_500K = 6'(`FDP_BIT_500K_NS * 1000 / 2 / `FDP_CLK_PS);
  localparam logic [5:0] HALF_300K = 6'(`FDP_BIT_300K_NS * 1000 / 2 / `FDP_CLK_PS);
  localparam logic [5:0] HALF_250K = 6'(`FDP_BIT_250K_NS * 1000 / 2 / `FDP_CLK_PS);
  localparam logic [2:0] PC_MAX = 3'(`FDP_PC_MAX_PS / `FDP_CLK_PS);

  logic [7:0] dor_ff;
  logic [7:0] cfg_ff;
  fdp_rate_t rate_ff;
  logic [2:0] pcsel_ff;
  logic swrst_ff;
  logic [7:0] cmd_ff;
  logic [1:0] left_ff;
  logic fifo_en_ff;
  logic frd_ff;
  logic fwr_ff;
  logic bstdis_ff;
  logic od_ff;
  logic [1:0] dens_ff;
  logic perp_ff;
  fdp_st_e st_ff;
  logic [5:0] bcnt_ff;
  logic tc_seen_ff;
  logic gate_ff;
  logic irq_ff;
  logic crc_err_ff;
  logic ovr_ff;
  logic urun_ff;
  logic drq_ff;
  logic gap_ff;
  fdp_byte_t mem_ff [`FDP_FIFO_DEPTH];
  logic [3:0] wp_ff;
  logic [3:0] rp_ff;
  logic [4:0] cnt_ff;
  logic [7:0] rsh_ff;
  logic [2:0] rbit_ff;
  logic rsync_ff;
  logic [15:0] crc_ff;
  logic rdn_s1_ff;
  logic rdn_s2_ff;
  logic rdn_s3_ff;

  logic [2:0] ofs;
  logic hit;
  logic en;
  logic alt;
  logic wr_reg;
  logic rd_reg;
  logic dack_act;
  logic core_rst;
  logic cmd_wr;
  logic op_wr;
  logic wr_op;
  logic rate_1m;
  logic [5:0] half;
  logic [2:0] pc;
  logic [5:0] gap_len;
  logic [5:0] gate_at;
  logic fifo_on;
  logic full;
  logic empty;
  logic hd_wr;
  logic hd_rd;
  logic push;
  logic pop;
  fdp_byte_t push_data;
  fdp_byte_t tx_byte;
  logic mfm_rdy;
  logic mfm_pulse;
  logic dds_vld;
  logic dds_bit;
  logic dds_locked;
  logic byte_done;
  logic tc_ev;
  logic rd_end;
  logic wr_end;
  logic dens_pin;
  logic [7:0] rd_mux;

  assign ofs = i_addr[2:0];
  assign hit = !i_aen && (i_addr[9:3] == `FDP_BASE);
  assign en = cfg_ff[`FDP_CFG_EN];
  assign alt = cfg_ff[`FDP_CFG_ALT];
  assign wr_reg = hit && i_wr && (en || ofs == `FDP_OFS_CFG);
  assign rd_reg = hit && i_rd && (en || ofs == `FDP_OFS_CFG);
  assign dack_act = !i_dack_n && en;
  assign core_rst = i_rst || swrst_ff || !dor_ff[`FDP_DOR_RSTN] || !en;
  assign cmd_wr = wr_reg && ofs == `FDP_OFS_DAT && st_ff == ST_IDLE;
  assign op_wr = wr_reg && ofs == `FDP_OFS_OPR && st_ff == ST_IDLE;
  assign wr_op = st_ff == ST_GAP || st_ff == ST_PRE || st_ff == ST_WDAT;
  assign rate_1m = rate_ff == 2'h3;

  always_comb begin
    unique case (rate_ff)
      2'h0: half = HALF_500K;
      2'h1: half = HALF_300K;
      2'h2: half = HALF_250K;
      2'h3: half = HALF_1M;
    endcase
  end

  // Precompensation in cycles, rounded up, capped at the maximum
  function automatic logic [2:0] pc_cycles(input logic [2:0] sel, input logic r1m);
    logic [2:0] k;
    logic [2:0] c;
    k = (sel == 3'h0) ? (r1m ? 3'h1 : 3'h3) : ((sel == 3'h7) ? 3'h0 : sel);
    c = 3'((32'(k) * `FDP_PC_STEP_PS + `FDP_CLK_PS - 1) / `FDP_CLK_PS);
    return (c > PC_MAX) ? PC_MAX : c;
  endfunction
  assign pc = pc_cycles(pcsel_ff, rate_1m);

  assign gap_len = (perp_ff && rate_1m) ? 6'(`FDP_GAP2_PERP) : 6'(`FDP_GAP2_STD);
  always_comb begin
    gate_at = gap_len;
    if (perp_ff && rate_1m) begin
      gate_at = gap_len - 6'(`FDP_LEAD_1M);
    end else if (perp_ff && rate_ff == 2'h0) begin
      gate_at = gap_len - 6'(`FDP_LEAD_500K);
    end
  end

  // Configuration and digital output registers survive soft reset
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cfg_ff <= `FDP_CFG_RST;
    end else if (hit && i_wr && ofs == `FDP_OFS_CFG) begin
      cfg_ff <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      dor_ff <= `FDP_DOR_RST;
    end else if (wr_reg && ofs == `FDP_OFS_DOR) begin
      dor_ff <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rate_ff <= `FDP_RATE_RST;
    end else if (wr_reg && (ofs == `FDP_OFS_DSR || ofs == `FDP_OFS_CCR)) begin
      rate_ff <= i_wdata[1:0];
    end
  end

  // Precompensation select and self-clearing soft reset
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pcsel_ff <= `FDP_PCSEL_RST;
      swrst_ff <= 1'b0;
    end else begin
      swrst_ff <= wr_reg && ofs == `FDP_OFS_DSR && i_wdata[`FDP_DSR_SWRST];
      if (wr_reg && ofs == `FDP_OFS_DSR) begin
        pcsel_ff <= i_wdata[4:2];
      end
    end
  end

  // Command byte counter; parameters follow the opcode
  always_ff @(posedge i_mclk) begin
    if (core_rst) begin
      cmd_ff <= 8'h00;
      left_ff <= 2'h0;
    end else if (cmd_wr) begin
      if (left_ff == 2'h0) begin
        cmd_ff <= i_wdata;
        unique case (i_wdata)
          `FDP_CMD_CONFIGURE: left_ff <= 2'h3;
          `FDP_CMD_MODE: left_ff <= 2'h1;
          `FDP_CMD_PERP: left_ff <= 2'h1;
          default: left_ff <= 2'h0;
        endcase
      end else begin
        left_ff <= left_ff - 2'h1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (core_rst) begin
      fifo_en_ff <= 1'b0;
      frd_ff <= 1'b1;
      fwr_ff <= 1'b1;
      bstdis_ff <= 1'b0;
      od_ff <= 1'b0;
      dens_ff <= 2'h0;
      perp_ff <= 1'b0;
    end else if (cmd_wr && left_ff != 2'h0) begin
      unique case (cmd_ff)
        `FDP_CMD_CONFIGURE: begin
          if (left_ff == 2'h2) begin
            fifo_en_ff <= !i_wdata[`FDP_CONF_EFIFO_N];
          end
        end
        `FDP_CMD_MODE: begin
          frd_ff <= i_wdata[`FDP_MODE_FRD];
          fwr_ff <= i_wdata[`FDP_MODE_FWR];
          bstdis_ff <= i_wdata[`FDP_MODE_BSTDIS];
          od_ff <= i_wdata[`FDP_MODE_OD];
          dens_ff <= i_wdata[`FDP_MODE_DENS +: 2];
        end
        `FDP_CMD_PERP: perp_ff <= i_wdata[`FDP_PERP_ON];
        default: perp_ff <= perp_ff;
      endcase
    end
  end

  // host data from the data port or under DACK; TC qualified by DACK
  assign hd_wr = ((wr_reg && ofs == `FDP_OFS_DAT) || (dack_act && i_wr)) && wr_op;
  assign hd_rd = ((rd_reg && ofs == `FDP_OFS_DAT) || (dack_act && i_rd)) && st_ff == ST_RDAT;
  assign tc_ev = dack_act && (i_rd || i_wr) && (alt ? !i_tc : i_tc);

  // FIFO only in path when enabled
  assign fifo_on = fifo_en_ff && (st_ff == ST_RDAT ? frd_ff : fwr_ff);
  assign full = fifo_on ? cnt_ff == 5'(`FDP_FIFO_DEPTH) : cnt_ff != 5'h00;
  assign empty = cnt_ff == 5'h00;
  assign byte_done = dds_vld && st_ff == ST_RDAT && rsync_ff && rbit_ff == 3'h7;
  assign push_data = (st_ff == ST_RDAT) ? {rsh_ff[6:0], dds_bit} : i_wdata;
  assign push = (st_ff == ST_RDAT) ? byte_done && !full : hd_wr && !full;
  assign pop = (st_ff == ST_RDAT) ? hd_rd && !empty : st_ff == ST_WDAT && mfm_rdy && !empty;

  // FIFO storage, one flop row per entry
  for (genvar g = 0; g < `FDP_FIFO_DEPTH; g++) begin : g_ent
    always_ff @(posedge i_mclk) begin
      if (push && wp_ff == 4'(g)) begin
        mem_ff[g] <= push_data;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (core_rst || op_wr) begin
      wp_ff <= 4'h0;
      rp_ff <= 4'h0;
      cnt_ff <= 5'h00;
    end else begin
      wp_ff <= wp_ff + 4'(push);
      rp_ff <= rp_ff + 4'(pop);
      cnt_ff <= cnt_ff + 5'(push) - 5'(pop);
    end
  end

  // Read pin passes three flops; edge found on the later pair only
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rdn_s1_ff <= 1'b1;
      rdn_s2_ff <= 1'b1;
      rdn_s3_ff <= 1'b1;
    end else begin
      rdn_s1_ff <= i_read_data_n;
      rdn_s2_ff <= rdn_s1_ff;
      rdn_s3_ff <= rdn_s2_ff;
    end
  end

  fdp_dds u_dds (
    .i_mclk(i_mclk),
    .i_rst(core_rst),
    .i_run(st_ff == ST_RDAT),
    .i_pulse(rdn_s3_ff && !rdn_s2_ff),
    .i_half(half),
    .o_bit_vld(dds_vld),
    .o_bit(dds_bit),
    .o_locked(dds_locked)
  );

  // Bytes align on the first one after lock, the sync mark lead
  always_ff @(posedge i_mclk) begin
    if (core_rst || op_wr) begin
      rsh_ff <= 8'h00;
      rbit_ff <= 3'h0;
      rsync_ff <= 1'b0;
      crc_ff <= 16'hffff;
    end else if (st_ff == ST_RDAT && dds_vld && (rsync_ff || dds_bit)) begin
      rsync_ff <= 1'b1;
      rsh_ff <= {rsh_ff[6:0], dds_bit};
      rbit_ff <= rbit_ff + 3'h1;
      crc_ff <= {crc_ff[14:0], 1'b0} ^ ({16{crc_ff[15] ^ dds_bit}} & 16'h1021);
    end
  end

  assign tx_byte = (st_ff == ST_GAP) ? `FDP_GAP_BYTE :
                   (st_ff == ST_PRE) ? `FDP_PRE_BYTE : mem_ff[rp_ff];

  fdp_mfm u_mfm (
    .i_mclk(i_mclk),
    .i_rst(core_rst),
    .i_run(wr_op),
    .i_half(half),
    .i_pc(pc),
    .i_byte(tx_byte),
    .o_byte_rdy(mfm_rdy),
    .o_pulse(mfm_pulse)
  );

  // A byte boundary with nothing queued ends the write
  assign wr_end = st_ff == ST_WDAT && mfm_rdy && empty;
  assign rd_end = st_ff == ST_RDAT && tc_seen_ff;

  // Operation sequence: gap, preamble, data; or read until TC
  always_ff @(posedge i_mclk) begin
    if (core_rst) begin
      st_ff <= ST_IDLE;
      bcnt_ff <= 6'h00;
    end else begin
      unique case (st_ff)
        ST_IDLE: begin
          bcnt_ff <= 6'h00;
          if (op_wr && i_wdata[`FDP_OPR_RD]) begin
            st_ff <= ST_RDAT;
          end else if (op_wr && (i_wdata[`FDP_OPR_WR] || i_wdata[`FDP_OPR_FMT])) begin
            st_ff <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (mfm_rdy) begin
            bcnt_ff <= (bcnt_ff == gap_len - 6'h01) ? 6'h00 : bcnt_ff + 6'h01;
            if (bcnt_ff == gap_len - 6'h01) begin
              st_ff <= ST_PRE;
            end
          end
        end
        ST_PRE: begin
          if (mfm_rdy) begin
            bcnt_ff <= bcnt_ff + 6'h01;
            if (bcnt_ff == 6'(`FDP_PRE_LEN - 1)) begin
              st_ff <= ST_WDAT;
            end
          end
        end
        ST_WDAT: begin
          if (wr_end) begin
            st_ff <= ST_IDLE;
          end
        end
        ST_RDAT: begin
          if (rd_end) begin
            st_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (core_rst) begin
      gate_ff <= 1'b0;
    end else begin
      // Counts step at byte load, so a byte is out only once the next one loads
      gate_ff <= (st_ff == ST_GAP && bcnt_ff > gate_at) ||
                 (st_ff == ST_PRE && (bcnt_ff != 6'h00 || gate_at < gap_len)) ||
                 (st_ff == ST_WDAT && !wr_end);
    end
  end

  // Status flags; a setting event wins over a clear in the same cycle
  always_ff @(posedge i_mclk) begin
    if (core_rst) begin
      tc_seen_ff <= 1'b0;
      irq_ff <= 1'b0;
      crc_err_ff <= 1'b0;
      ovr_ff <= 1'b0;
      urun_ff <= 1'b0;
    end else begin
      if (op_wr) begin
        tc_seen_ff <= 1'b0;
        crc_err_ff <= 1'b0;
        ovr_ff <= 1'b0;
        urun_ff <= 1'b0;
      end
      if (rd_reg && ofs == `FDP_OFS_STA) begin
        irq_ff <= 1'b0;
      end
      if (tc_ev) begin
        tc_seen_ff <= 1'b1;
      end
      if (byte_done && full) begin
        ovr_ff <= 1'b1;
      end
      if (wr_end && !tc_seen_ff) begin
        urun_ff <= 1'b1;
      end
      if (rd_end && crc_ff != 16'h0000) begin
        crc_err_ff <= 1'b1;
      end
      if (rd_end || wr_end) begin
        irq_ff <= 1'b1;
      end
    end
  end

  // DMA request; non-burst drops it after each byte
  always_ff @(posedge i_mclk) begin
    if (core_rst) begin
      drq_ff <= 1'b0;
      gap_ff <= 1'b0;
    end else begin
      gap_ff <= bstdis_ff && dack_act && (i_rd || i_wr);
      drq_ff <= !tc_seen_ff && !tc_ev && !gap_ff && !(bstdis_ff && dack_act && (i_rd || i_wr)) &&
                ((st_ff == ST_RDAT && cnt_ff > 5'(pop)) || (wr_op && !full && !hd_wr));
    end
  end

  assign o_irq = irq_ff;
  assign o_drq = drq_ff;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_irq_oe <= 1'b0;
      o_drq_oe <= 1'b0;
    end else begin
      o_irq_oe <= alt || dor_ff[`FDP_DOR_DMAEN];
      o_drq_oe <= alt || dor_ff[`FDP_DOR_DMAEN];
    end
  end

  // density: auto, forced low, forced high
  always_comb begin
    unique case (dens_ff)
      2'h1: dens_pin = 1'b0;
      2'h2: dens_pin = 1'b1;
      default: dens_pin = rate_ff == 2'h0 || rate_1m;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_write_data_n <= 1'b1;
      o_write_data_oe <= 1'b1;
      o_write_gate_n <= 1'b1;
      o_write_gate_oe <= 1'b1;
      o_density_select <= 1'b0;
      o_density_oe <= 1'b1;
    end else begin
      o_write_data_n <= od_ff ? 1'b0 : !mfm_pulse;
      o_write_data_oe <= od_ff ? mfm_pulse : 1'b1;
      o_write_gate_n <= od_ff ? 1'b0 : !gate_ff;
      o_write_gate_oe <= od_ff ? gate_ff : 1'b1;
      o_density_select <= od_ff ? 1'b0 : (alt ? !dens_pin : dens_pin);
      o_density_oe <= od_ff ? (alt ? dens_pin : !dens_pin) : 1'b1;
    end
  end

  // Read data mux; DMA reads return the FIFO head
  always_comb begin
    rd_mux = 8'h00;
    if (dack_act && i_rd) begin
      rd_mux = mem_ff[rp_ff];
    end else if (rd_reg) begin
      unique case (ofs)
        `FDP_OFS_STA: rd_mux = {irq_ff, crc_err_ff, ovr_ff, urun_ff, dds_locked, perp_ff, alt, en};
        `FDP_OFS_MDR: rd_mux = {fifo_en_ff, perp_ff, dens_ff, od_ff, bstdis_ff, fwr_ff, frd_ff};
        `FDP_OFS_DOR: rd_mux = dor_ff;
        `FDP_OFS_CFG: rd_mux = cfg_ff;
        `FDP_OFS_DSR: rd_mux = {1'b1, st_ff == ST_RDAT, st_ff != ST_IDLE, cnt_ff};
        `FDP_OFS_DAT: rd_mux = mem_ff[rp_ff];
        `FDP_OFS_OPR: rd_mux = {3'h0, st_ff};
        `FDP_OFS_CCR: rd_mux = {3'h0, pcsel_ff, rate_ff};
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= rd_mux;
    end
  end
endmodule

// file: sim/fdp_props.sv
// Port checker for the floppy data path
module fdp_props (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [9:0] i_addr,
  input wire logic i_aen,
  input wire logic i_rd,
  input wire logic i_dack_n,
  input wire logic [7:0] o_rdata,
  input wire logic o_irq_oe,
  input wire logic o_drq_oe,
  input wire logic o_write_data_n,
  input wire logic o_write_data_oe,
  input wire logic o_write_gate_n,
  input wire logic o_write_gate_oe,
  input wire logic o_density_select,
  input wire logic o_density_oe
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Flux pulse on the wire in either drive style
  wire pls = o_write_data_oe && !o_write_data_n;
  // Tightest MFM spacing survives the largest shift
  sequence s_gap;
    !pls [*8];
  endsequence
  chk_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00) else $error("stray read data");
  chk_aen_refuse: assert property (
    $past(i_rd) && $past(i_aen) && $past(i_dack_n) |-> !o_rdata) else $error("aen read answered");
  chk_base_refuse: assert property (
    $past(i_rd) && ($past(i_addr) >> 3) != 10'h07e && $past(i_dack_n) |-> !o_rdata) else $error("foreign read");
  chk_reset_quiet: assert property (disable iff (1'b0)
    i_rst |=> !o_irq_oe && !o_drq_oe && o_write_gate_n && o_write_gate_oe && o_write_data_oe)
    else $error("reset pins");
  chk_pulse_gap: assert property (
    pls |=> s_gap) else $error("pulses too close");
  chk_wd_od: assert property (
    !o_write_data_oe |-> !o_write_data_n) else $error("data line level");
  chk_gate_od: assert property (
    !o_write_gate_oe |-> !o_write_gate_n) else $error("gate line level");
  chk_dens_od: assert property (
    !o_density_oe |-> !o_density_select) else $error("density line level");
endmodule
bind fdp_top fdp_props fdp_props_i (.*);

// file: sim/fdp_drive.sv
// Drive model: scripted read stream, count of gated write pulses
module fdp_drive (
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic i_wd_n,
  input wire logic i_gate_n,
  output logic o_rd_n = 1'b1,
  output int o_wcnt = 0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Read stream at 1 Mbps, 20 clocks a cell: 24 zero cells of preamble, then one byte
  int k = 0;
  logic [32:0] rbits = {1'b0, 32'h000000c3};
  // clock pulse between zeros, mid-cell pulse for a one; idle at pull-up level
  always @(posedge i_mclk) begin
    if (i_go) begin
      k <= (k == 19) ? 0 : k + 1;
      if (k == 19) rbits <= {rbits[31:0], 1'b0};
    end
    o_rd_n <= !(i_go && ((k == 0 && !rbits[32] && !rbits[31]) || (k == 10 && rbits[31])));
  end
  // pulses count only under the gate
  always @(posedge i_mclk) if (!i_gate_n && !i_wd_n) o_wcnt <= o_wcnt + 1;
endmodule

// file: sim/tb_top.sv
// Bench for the floppy data path: bus, DMA and drive traffic
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 0, i_rst = 1, i_aen = 0, i_wr = 0, i_rd = 0, i_dack_n = 1, i_tc = 0;
  logic [9:0] i_addr = 10'h3f0;
  logic [7:0] i_wdata = 8'h00, v;
  logic [6:0] hi = 7'h7e;
  logic go = 0;
  logic [7:0] cmds [8] = '{8'h13, 8'h00, 8'h00, 8'h00, 8'h12, 8'h01, 8'h01, 8'h0b};
  wire logic [7:0] o_rdata;
  wire logic o_irq, o_irq_oe, o_drq, o_drq_oe, i_read_data_n, o_write_data_n, o_write_data_oe;
  wire logic o_write_gate_n, o_write_gate_oe, o_density_select, o_density_oe;
  int mismatches = 0, samples_checked = 0, n, wcnt;
  // Released lines float high through terminators
  wire wd_line = o_write_data_oe ? o_write_data_n : 1'b1;
  wire gate_line = o_write_gate_oe ? o_write_gate_n : 1'b1;
  initial forever #25 i_mclk = ~i_mclk;
  fdp_top fdp_top_i (.*);
  fdp_drive fdp_drive_i (.i_mclk(i_mclk), .i_go(go), .i_wd_n(wd_line), .i_gate_n(gate_line),
    .o_rd_n(i_read_data_n), .o_wcnt(wcnt));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One strobe cycle then idle, so strobes never overlap
  task bus(input logic w, input logic [1:0] k, input logic [2:0] a, input logic [7:0] d, m, e);
    @(posedge i_mclk);
    i_addr <= {hi, a};
    i_wdata <= d;
    i_wr <= w;
    i_rd <= !w;
    i_dack_n <= !k[0];
    i_tc <= k[1];
    @(posedge i_mclk);
    {i_wr, i_rd, i_dack_n, i_tc} <= 4'h2;
    #1 v = o_rdata;
    if (!w) chk(v & m, e);
  endtask
  task pins(input logic [7:0] e);
    repeat (3) @(posedge i_mclk);
    #1 chk({4'h0, o_irq_oe, o_drq_oe, o_write_data_oe, o_write_gate_oe}, e);
  endtask
  // Bounded wait: 0 gate, 1 DMA request, 2 interrupt
  task till(input int s);
    for (n = 0; n < 20000 && (s == 2 ? !o_irq : s ? !o_drq : gate_line) !== 1'b0; n++) @(posedge i_mclk) #1;
    if (n == 20000) mismatches++;
  endtask
  task finish_test;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    bus(0, 0, 3, 0, 8'hff, 8'h00);
    bus(0, 0, 0, 0, 8'hff, 8'h00);
    bus(1, 0, 2, 8'h0c, 0, 0);
    bus(1, 0, 3, 8'h08, 0, 0);
    bus(0, 0, 2, 0, 8'hff, 8'h00);
    @(posedge i_mclk) i_aen <= 1'b1;
    bus(0, 0, 3, 0, 8'hff, 8'h00);
    @(posedge i_mclk) i_aen <= 1'b0;
    hi = 7'h3d;
    bus(0, 0, 3, 0, 8'hff, 8'h00);
    hi = 7'h7e;
    bus(1, 0, 2, 8'h04, 0, 0);
    pins(8'h03);
    bus(0, 0, 7, 0, 8'hff, 8'h02);
    bus(0, 0, 1, 0, 8'h80, 8'h00);
    foreach (cmds[i]) bus(1, 0, 5, cmds[i], 0, 0);
    bus(0, 0, 1, 0, 8'hcf, 8'hcb);
    pins(8'h00);
    bus(1, 0, 5, 8'h01, 0, 0);
    bus(1, 0, 5, 8'h03, 0, 0);
    // Every rate through both rate registers, every shift code through DSR
    for (int r = 0; r < 32; r++) begin
      bus(1, 0, 4, 8'(r), 0, 0);
      bus(0, 0, 7, 0, 8'hff, 8'(r));
      bus(1, 0, 7, {6'h0, ~r[1:0]}, 0, 0);
      bus(0, 0, 7, 0, 8'hff, {3'h0, r[4:2], ~r[1:0]});
    end
    bus(1, 0, 3, 8'h0c, 0, 0);
    pins(8'h0f);
    chk({7'h0, o_density_select}, 8'h00);
    bus(0, 0, 0, 0, 8'h03, 8'h03);
    bus(1, 0, 3, 8'h08, 0, 0);
    pins(8'h03);
    bus(1, 0, 2, 8'h0c, 0, 0);
    pins(8'h0f);
    // Perpendicular write at 1 Mbps: byte time is 160 cycles
    bus(1, 0, 4, 8'h03, 0, 0);
    bus(1, 0, 6, 8'h02, 0, 0);
    till(0);
    chk(8'((n + 80) / 160), 8'h03);
    for (int i = 0; i < 4; i++) begin
      till(1);
      bus(1, i == 3 ? 3 : 1, 5, 8'(i), 0, 0);
    end
    till(2);
    chk({7'h0, o_irq}, 8'h01);
    chk(8'(wcnt > 0), 8'h01);
    bus(0, 0, 0, 0, 8'h80, 8'h80);
    repeat (2) @(posedge i_mclk);
    chk({7'h0, o_irq}, 8'h00);
    // Read at 1 Mbps: lock on preamble, one byte by DMA with TC, no CRC bytes follow
    bus(1, 0, 6, 8'h01, 0, 0);
    go = 1'b1;
    till(1);
    bus(0, 3, 5, 0, 8'hff, 8'hc3);
    bus(0, 0, 0, 0, 8'hc0, 8'hc0);
    chk({6'h0, o_density_select, o_density_oe}, 8'h03);
    finish_test;
  end
  // Run needs about 10000 cycles; past 50000 it has hung
  initial begin
    #2500000;
    mismatches++;
    finish_test;
  end
endmodule
